// ### playback_sequencer.v
// Waveform playback sequencer: address/length/repeat counters, run modes, sample serialiser
//
// Functional notes
// - Each location holds sample plus two markers
// - Length 960 to depth, multiple of four
// - Serialiser emits one sample per clock
// - Run mode governs the address control
// - Continuous mode loops regardless of triggers
// - Triggered mode plays once per trigger
// - Triggered sequence plays through exactly once
// - Gated mode outputs only while gate true
// - Trigger edge and gate level selectable
// - Enhanced mode steps sequence on triggers, jump commands
// - Events redirect sequence in enhanced mode
// - Start address loaded into address counter
// - Length counter expiry marks waveform end
// - Counters step on quarter-rate enable
// - Repeat counter replays waveform that often
// - Reference selectable internal or external
// - Internal trigger timer 1 us to 10 s
`timescale 1ns/1ps
`include "playback_consts.vh"
module playback_sequencer #(
    parameter MEM_DEPTH = `MEM_POINTS,
    parameter ADDR_W = 22,
    parameter SEQ_DEPTH = 8,
    parameter IDX_W = 3,
    parameter REP_W = 16,
    parameter TRIG_MAX = `TRIG_MAX_CYC
) (
    // Clock and reset
    input wire REF_CLK,
    input wire SYS_RST,
    // Avalon-MM slave
    input wire [5:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    // Trigger and event inputs
    input wire EXT_TRIGGER_INPUT,
    input wire FORCE_TRIGGER_BTN,
    input wire EXT_EVENT_INPUT,
    input wire FORCE_EVENT_BTN,
    // Clock reference selection
    input wire REF_CLOCK_INPUT,
    output wire REF_SELECT_EXT,
    // Waveform memory read port, four points per word
    output reg [ADDR_W-1:0] MEM_ADDR,
    output reg MEM_RD,
    input wire [4*(`SAMPLE_W+`MARKER_W)-1:0] MEM_DATA,
    // Converter and marker outputs
    output wire [`SAMPLE_W-1:0] SAMPLE_OUT,
    output wire [`MARKER_W-1:0] MARKER_OUT
);
    localparam PT_W = `SAMPLE_W + `MARKER_W;
    localparam [31:0] LEN_MIN = `LEN_MIN_PTS;
    localparam [31:0] DEPTH = MEM_DEPTH;
    localparam [31:0] IVL_MIN = `TRIG_MIN_CYC;
    localparam [31:0] IVL_MAX = TRIG_MAX;
    localparam ST_IDLE = 1'b0;
    localparam ST_PLAY = 1'b1;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg [31:0] ctrl_r;
    reg [31:0] ivl_r;
    reg [IDX_W-1:0] sel_r;
    reg [IDX_W:0] cnt_r;
    reg len_err_r;
    reg ack_r;
    reg [ADDR_W-1:0] seg_start [0:SEQ_DEPTH-1];
    reg [ADDR_W:0] seg_len [0:SEQ_DEPTH-1];
    reg [REP_W-1:0] seg_rep [0:SEQ_DEPTH-1];
    reg [IDX_W-1:0] seg_jmp [0:SEQ_DEPTH-1];
    // Playback state
    reg state_r;
    reg [ADDR_W-1:0] addr_r;
    reg [ADDR_W:0] len_r;
    reg [REP_W-1:0] rep_r;
    reg [IDX_W-1:0] idx_r;
    reg [1:0] phase_r;
    reg [4*PT_W-1:0] sh_r;
    reg trg_prev_r;
    reg ev_prev_r;
    reg tbtn_prev_r;
    reg ebtn_prev_r;
    reg trig_pend_r;
    reg ev_pend_r;
    reg jump_pend_r;
    reg [31:0] tmr_r;

    wire [1:0] mode = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire run = ctrl_r[`CTRL_RUN];
    wire wr_ok = AVS_WRITE & ack_r;
    wire cmd_wr = wr_ok & (AVS_ADDRESS == `OFS_CMD);
    wire ce4 = (phase_r == 2'h3);
    // Length check on the point count written by software
    wire len_ok = (AVS_WRITEDATA >= LEN_MIN) && (AVS_WRITEDATA <= DEPTH) &&
                  (AVS_WRITEDATA[1:0] == 2'h0);

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle, then the answer
    // ------------------------------------------------------------
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
    assign REF_SELECT_EXT = ctrl_r[`CTRL_REF_EXT];

    // Acknowledge and read data
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ack_r <= 1'b0;
            AVS_READDATA <= 32'h00000000;
        end else begin
            ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
            if (AVS_READ & ~ack_r) begin
                case (AVS_ADDRESS)
                    `OFS_CTRL: AVS_READDATA <= ctrl_r;
                    `OFS_STATUS: AVS_READDATA <= {16'h0000, 5'h00, REF_CLOCK_INPUT,
                        {(8-IDX_W){1'b0}}, idx_r, len_err_r, state_r};
                    `OFS_SEG_SEL: AVS_READDATA <= {{(32-IDX_W){1'b0}}, sel_r};
                    `OFS_SEG_START: AVS_READDATA <= {{(30-ADDR_W){1'b0}},
                        seg_start[sel_r], 2'h0};
                    `OFS_SEG_LEN: AVS_READDATA <= {{(29-ADDR_W){1'b0}},
                        seg_len[sel_r], 2'h0};
                    `OFS_SEG_REP: AVS_READDATA <= {{(32-REP_W){1'b0}}, seg_rep[sel_r]};
                    `OFS_SEG_JUMP: AVS_READDATA <= {{(32-IDX_W){1'b0}}, seg_jmp[sel_r]};
                    `OFS_TRIG_IVL: AVS_READDATA <= ivl_r;
                    `OFS_SEQ_COUNT: AVS_READDATA <= {{(31-IDX_W){1'b0}}, cnt_r};
                    default: AVS_READDATA <= 32'h00000000;
                endcase
            end
        end
    end

    // Control registers; a bad length is refused and flagged
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl_r <= `CTRL_RESET;
            ivl_r <= `IVL_RESET;
            sel_r <= {IDX_W{1'b0}};
            cnt_r <= {{IDX_W{1'b0}}, 1'b1};
            len_err_r <= 1'b0;
        end else begin
            if (wr_ok && AVS_ADDRESS == `OFS_CTRL)
                ctrl_r <= AVS_WRITEDATA;
            if (wr_ok && AVS_ADDRESS == `OFS_TRIG_IVL)
                ivl_r <= AVS_WRITEDATA;
            if (wr_ok && AVS_ADDRESS == `OFS_SEG_SEL)
                sel_r <= AVS_WRITEDATA[IDX_W-1:0];
            if (wr_ok && AVS_ADDRESS == `OFS_SEQ_COUNT)
                cnt_r <= AVS_WRITEDATA[IDX_W:0];
            // A new error beats a clear in the same cycle
            if (wr_ok && AVS_ADDRESS == `OFS_SEG_LEN && !len_ok)
                len_err_r <= 1'b1;
            else if (wr_ok && AVS_ADDRESS == `OFS_STATUS && AVS_WRITEDATA[`STAT_LEN_ERR])
                len_err_r <= 1'b0;
        end
    end

    // Segment table; arrays hold no reset, software programs them before run
    always @(posedge REF_CLK) begin
        if (wr_ok && AVS_ADDRESS == `OFS_SEG_START)
            seg_start[sel_r] <= AVS_WRITEDATA[ADDR_W+1:2];
        if (wr_ok && AVS_ADDRESS == `OFS_SEG_LEN && len_ok)
            seg_len[sel_r] <= AVS_WRITEDATA[ADDR_W+2:2];
        if (wr_ok && AVS_ADDRESS == `OFS_SEG_REP)
            seg_rep[sel_r] <= AVS_WRITEDATA[REP_W-1:0];
        if (wr_ok && AVS_ADDRESS == `OFS_SEG_JUMP)
            seg_jmp[sel_r] <= AVS_WRITEDATA[IDX_W-1:0];
    end

    // ------------------------------------------------------------
    // Trigger, gate and event conditioning
    // ------------------------------------------------------------
    wire trg_lvl = EXT_TRIGGER_INPUT ^ ctrl_r[`CTRL_SLOPE_NEG];
    wire ext_edge = trg_lvl & ~trg_prev_r & ~ctrl_r[`CTRL_TRIG_INT];
    wire btn_edge = FORCE_TRIGGER_BTN & ~tbtn_prev_r;
    wire [31:0] ivl_eff = (ivl_r < IVL_MIN) ? IVL_MIN :
                          (ivl_r > IVL_MAX) ? IVL_MAX : ivl_r;
    wire tick = ctrl_r[`CTRL_TRIG_INT] & run & (tmr_r >= ivl_eff - 32'h00000001);
    wire trig_any = ext_edge | btn_edge | tick |
                    (cmd_wr & AVS_WRITEDATA[`CMD_TRIG]);
    wire ev_any = (EXT_EVENT_INPUT & ~ev_prev_r) | (FORCE_EVENT_BTN & ~ebtn_prev_r) |
                  (cmd_wr & AVS_WRITEDATA[`CMD_EVENT]);
    wire jump_cmd = cmd_wr & AVS_WRITEDATA[`CMD_JUMP];
    // Gate true while the polarised input (ignored when the internal timer triggers), the button or the remote level is high
    wire gate = (trg_lvl & ~ctrl_r[`CTRL_TRIG_INT]) | FORCE_TRIGGER_BTN |
                ctrl_r[`CTRL_GATE_CMD];

    // Edge history and internal interval timer
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            trg_prev_r <= 1'b0;
            ev_prev_r <= 1'b0;
            tbtn_prev_r <= 1'b0;
            ebtn_prev_r <= 1'b0;
            tmr_r <= 32'h00000000;
        end else begin
            trg_prev_r <= trg_lvl;
            ev_prev_r <= EXT_EVENT_INPUT;
            tbtn_prev_r <= FORCE_TRIGGER_BTN;
            ebtn_prev_r <= FORCE_EVENT_BTN;
            if (!ctrl_r[`CTRL_TRIG_INT] || !run || tick)
                tmr_r <= 32'h00000000;
            else
                tmr_r <= tmr_r + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // Sequence stepping: where the next pass starts
    // ------------------------------------------------------------
    reg [IDX_W-1:0] nxt_idx;
    reg seq_done;
    wire [IDX_W:0] cnt_eff = (cnt_r == {(IDX_W+1){1'b0}}) ? {{IDX_W{1'b0}}, 1'b1} : cnt_r;
    wire [IDX_W:0] idx_inc = {1'b0, idx_r} + {{IDX_W{1'b0}}, 1'b1};
    wire enh = (mode == `MODE_ENH);
    wire pass_end = (len_r == {{ADDR_W{1'b0}}, 1'b1});
    wire rep_left = (rep_r > {{(REP_W-1){1'b0}}, 1'b1});

    // Pick the next entry: event jump, then sequential, then wrap
    always @* begin
        nxt_idx = idx_inc[IDX_W-1:0];
        seq_done = 1'b0;
        if (enh && ev_pend_r) begin
            nxt_idx = seg_jmp[idx_r];
        end else if (idx_inc >= cnt_eff) begin
            nxt_idx = {IDX_W{1'b0}};
            // Continuous and gated loop; triggered and enhanced end the pass
            seq_done = (mode == `MODE_TRIG) || enh;
        end
    end

    // ------------------------------------------------------------
    // Address, length and repeat counters on the quarter-rate enable
    // ------------------------------------------------------------
    wire start_ok = run && ((mode == `MODE_CONT) || (mode == `MODE_GATED && gate) ||
                    ((mode == `MODE_TRIG || enh) && trig_pend_r));
    wire step_now = enh && (trig_pend_r || jump_pend_r);
    wire consume = ce4 & (state_r == ST_IDLE ? start_ok : step_now);

    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            phase_r <= 2'h0;
            state_r <= ST_IDLE;
            addr_r <= {ADDR_W{1'b0}};
            len_r <= {(ADDR_W+1){1'b0}};
            rep_r <= {REP_W{1'b0}};
            idx_r <= {IDX_W{1'b0}};
            MEM_ADDR <= {ADDR_W{1'b0}};
            MEM_RD <= 1'b0;
            trig_pend_r <= 1'b0;
            ev_pend_r <= 1'b0;
            jump_pend_r <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            // A request seen in the consuming cycle stays pending
            trig_pend_r <= trig_any | (trig_pend_r & ~consume);
            jump_pend_r <= jump_cmd | (jump_pend_r & ~(consume & enh));
            if (ev_any)
                ev_pend_r <= 1'b1;
            else if (ce4 && state_r == ST_PLAY && pass_end && !rep_left)
                ev_pend_r <= 1'b0;
            if (ce4) begin
                MEM_RD <= 1'b0;
                case (state_r)
                    ST_IDLE: begin
                        if (start_ok) begin
                            state_r <= ST_PLAY;
                            idx_r <= {IDX_W{1'b0}};
                            addr_r <= seg_start[0];
                            len_r <= seg_len[0];
                            rep_r <= seg_rep[0];
                        end
                    end
                    ST_PLAY: begin
                        if (!run || (mode == `MODE_GATED && !gate)) begin
                            state_r <= ST_IDLE;
                        end else if (step_now) begin
                            // Trigger steps on, remote jump follows the entry's target
                            idx_r <= jump_pend_r ? seg_jmp[idx_r] : nxt_idx;
                            addr_r <= seg_start[jump_pend_r ? seg_jmp[idx_r] : nxt_idx];
                            len_r <= seg_len[jump_pend_r ? seg_jmp[idx_r] : nxt_idx];
                            rep_r <= seg_rep[jump_pend_r ? seg_jmp[idx_r] : nxt_idx];
                        end else begin
                            MEM_ADDR <= addr_r;
                            MEM_RD <= 1'b1;
                            addr_r <= addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
                            len_r <= len_r - {{ADDR_W{1'b0}}, 1'b1};
                            if (pass_end && rep_left) begin
                                rep_r <= rep_r - {{(REP_W-1){1'b0}}, 1'b1};
                                addr_r <= seg_start[idx_r];
                                len_r <= seg_len[idx_r];
                            end else if (pass_end && seq_done) begin
                                state_r <= ST_IDLE;
                            end else if (pass_end) begin
                                idx_r <= nxt_idx;
                                addr_r <= seg_start[nxt_idx];
                                len_r <= seg_len[nxt_idx];
                                rep_r <= seg_rep[nxt_idx];
                            end
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Serialiser: load four points per enable, shift one per clock
    // ------------------------------------------------------------
    // Memory has up to three clocks to answer; the fetch still standing is the one loaded
    always @(posedge REF_CLK) begin
        if (SYS_RST)
            sh_r <= {4{{`MARKER_W{1'b0}}, `IDLE_SAMPLE}};
        else if (ce4)
            sh_r <= MEM_RD ? MEM_DATA : {4{{`MARKER_W{1'b0}}, `IDLE_SAMPLE}};
        else
            sh_r <= {{`MARKER_W{1'b0}}, `IDLE_SAMPLE, sh_r[4*PT_W-1:PT_W]};
    end

    assign SAMPLE_OUT = sh_r[`SAMPLE_W-1:0];
    assign MARKER_OUT = sh_r[PT_W-1:`SAMPLE_W];
endmodule // playback_sequencer

// ### playback_consts.vh
// Register map, field positions, reset values and timing counts of the playback sequencer
`ifndef PLAYBACK_CONSTS_VH
`define PLAYBACK_CONSTS_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 6'h00
`define OFS_STATUS 6'h04
`define OFS_SEG_SEL 6'h08
`define OFS_SEG_START 6'h0C
`define OFS_SEG_LEN 6'h10
`define OFS_SEG_REP 6'h14
`define OFS_SEG_JUMP 6'h18
`define OFS_TRIG_IVL 6'h1C
`define OFS_SEQ_COUNT 6'h20
`define OFS_CMD 6'h24
// ------------------------------------------------------------
// Fields and codes
// ------------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_SLOPE_NEG 3
`define CTRL_TRIG_INT 4
`define CTRL_REF_EXT 5
`define CTRL_GATE_CMD 6
`define CMD_TRIG 0
`define CMD_EVENT 1
`define CMD_JUMP 2
`define STAT_PLAYING 0
`define STAT_LEN_ERR 1
`define MODE_CONT 2'h0
`define MODE_TRIG 2'h1
`define MODE_GATED 2'h2
`define MODE_ENH 2'h3
`define CTRL_RESET 32'h00000000
`define IVL_RESET 32'h000000C8
// ------------------------------------------------------------
// Waveform geometry and timing
// ------------------------------------------------------------
`define SAMPLE_W 8
`define MARKER_W 2
`define GROUP_PTS 4
`define LEN_MIN_PTS 960
`define MEM_POINTS 16777216
`define IDLE_SAMPLE 8'h80
`define CLK_NS 5
`define CLK_KHZ 200000
`define TRIG_MIN_NS 1000
`define TRIG_MIN_CYC ((`TRIG_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define TRIG_MAX_MS 10000
`define TRIG_MAX_CYC (`TRIG_MAX_MS * `CLK_KHZ)
`endif

// ### wave_memory.sv
// Waveform memory model that answers the sequencer's four-point group fetches
`timescale 1ns/1ps
module wave_memory #(parameter ADDR_W = 22, parameter LAT = 3) (
    // Clock
    input wire clk,
    // Group fetch from the sequencer
    input wire [ADDR_W-1:0] mem_addr,
    input wire mem_rd,
    // Four points, point0 lowest
    output reg [39:0] mem_data
);
    integer held = 0;
    integer k;
    reg [ADDR_W-1:0] last = 0;
    initial mem_data = 40'h0;
    // Answer only after LAT cycles on one address; until then the word toggles so
    // a design that samples too early never sees a valid point
    always @(posedge clk) begin
        held = (mem_rd && mem_addr == last) ? held + 1 : (mem_rd ? 1 : 0);
        last = mem_addr;
        for (k = 0; k < 4; k = k + 1) begin
            mem_data[k*10 +: 10] <= (held >= LAT) ?
                {mem_addr[1:0] ^ k[1:0], mem_addr[5:0], k[1:0]} :
                ~mem_data[k*10 +: 10];
        end
    end
endmodule // wave_memory

// ### playback_sequencer_assertions.sv
// Port-level checker for the playback sequencer
`timescale 1ns/1ps
`include "playback_consts.vh"
module playback_sequencer_assertions #(parameter ADDR_W = 22) (
    // Clock and reset
    input wire REF_CLK,
    input wire SYS_RST,
    // Register bus
    input wire [5:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    // Pins
    input wire EXT_TRIGGER_INPUT,
    input wire FORCE_TRIGGER_BTN,
    input wire REF_SELECT_EXT,
    input wire [ADDR_W-1:0] MEM_ADDR,
    input wire MEM_RD,
    input wire [`SAMPLE_W-1:0] SAMPLE_OUT,
    input wire [`MARKER_W-1:0] MARKER_OUT
);
    reg [31:0] ctrl_r;
    wire wd_ref = AVS_WRITEDATA[`CTRL_REF_EXT];
    wire ctrl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `OFS_CTRL;
    // Shadow of the control word, so mode checks need no internal signal
    always @(posedge REF_CLK) begin
        if (SYS_RST) ctrl_r <= 32'h0;
        else if (ctrl_wr) ctrl_r <= AVS_WRITEDATA;
    end
    // Gate as the rules define it; the pin is ignored while the timer triggers
    wire gate_on = (!ctrl_r[4] && (EXT_TRIGGER_INPUT ^ ctrl_r[3])) || FORCE_TRIGGER_BTN || ctrl_r[6];
    wire gated_off = ctrl_r[0] && ctrl_r[2:1] == `MODE_GATED && !gate_on;
    wire cont_on = ctrl_r[0] && ctrl_r[2:1] == `MODE_CONT;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    sequence fetch_open; $rose(MEM_RD); endsequence
    sequence fetch_hold; MEM_RD [*4]; endsequence
    sequence req_open; $rose(AVS_READ || AVS_WRITE); endsequence
    sequence one_wait; AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endsequence
    bus_answer_a: assert property (req_open |-> one_wait) else $error("bus answer late");
    bus_idle_a: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST) else $error("idle wait");
    fetch_hold_a: assert property (fetch_open |-> fetch_hold) else $error("fetch short");
    group_addr_a: assert property (MEM_RD && $changed(MEM_ADDR) |=> $stable(MEM_ADDR) [*3])
        else $error("group address moved");
    ref_select_a: assert property (ctrl_wr |=> REF_SELECT_EXT == $past(wd_ref))
        else $error("reference select");
    hole_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > `OFS_CMD
        |-> AVS_READDATA == 32'h0) else $error("unmapped read");
    reset_idle_a: assert property ($fell(SYS_RST) |-> SAMPLE_OUT == `IDLE_SAMPLE &&
        MARKER_OUT == 2'h0 && !MEM_RD) else $error("reset output");
    fetch_stopped_a: assert property (!ctrl_r[0] && !MEM_RD |=> !MEM_RD) else $error("fetch idle");
    cont_runs_a: assert property (cont_on && !MEM_RD |-> ##[1:12] MEM_RD)
        else $error("continuous gap");
    gate_stop_a: assert property (gated_off [*8] |-> !MEM_RD) else $error("gate closed");
endmodule // playback_sequencer_assertions
bind playback_sequencer playback_sequencer_assertions #(.ADDR_W(ADDR_W)) checker_inst (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_TRIGGER_INPUT(EXT_TRIGGER_INPUT),
    .FORCE_TRIGGER_BTN(FORCE_TRIGGER_BTN), .REF_SELECT_EXT(REF_SELECT_EXT),
    .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .SAMPLE_OUT(SAMPLE_OUT), .MARKER_OUT(MARKER_OUT));

// ### testbench.sv
// Self-checking bench for the playback sequencer
`timescale 1ns/1ps
`include "playback_consts.vh"
module testbench;
    localparam GRPS = `LEN_MIN_PTS / 4;
    reg REF_CLK = 1'b0;
    reg SYS_RST = 1'b1;
    reg [5:0] addr = 6'h0;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdata = 32'h0;
    reg trig_pin = 1'b0;
    reg trig_btn = 1'b0;
    reg ev_pin = 1'b0;
    reg ref_pin = 1'b0;
    wire [31:0] rdata;
    wire wait_req, ref_ext, mem_rd;
    wire [21:0] mem_addr;
    wire [39:0] mem_data;
    wire [7:0] smp;
    wire [1:0] mrk;
    integer error_cnt = 0;
    integer compares = 0;
    integer i, j, n, s;
    reg [31:0] seed;
    reg [31:0] got;
    reg prev_rd = 1'b0;
    reg [21:0] fetch_q[$];
    always #2.5 REF_CLK = ~REF_CLK;
    playback_sequencer #(.TRIG_MAX(1000)) playback_sequencer_inst (.REF_CLK(REF_CLK),
        .SYS_RST(SYS_RST), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .EXT_TRIGGER_INPUT(trig_pin), .FORCE_TRIGGER_BTN(trig_btn), .EXT_EVENT_INPUT(ev_pin),
        .FORCE_EVENT_BTN(1'b0), .REF_CLOCK_INPUT(ref_pin), .REF_SELECT_EXT(ref_ext),
        .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_DATA(mem_data), .SAMPLE_OUT(smp),
        .MARKER_OUT(mrk));
    wave_memory #(.LAT(3)) wave_memory_inst (.clk(REF_CLK), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_data(mem_data));
    // Log each new group address mid-cycle, where registered outputs are settled
    always @(negedge REF_CLK) begin
        if (mem_rd && (!prev_rd || fetch_q.size() == 0 || mem_addr != fetch_q[$]))
            fetch_q.push_back(mem_addr);
        prev_rd <= mem_rd;
    end
    function [31:0] xs(input [31:0] v);
        reg [31:0] x;
        begin
            x = v ^ (v << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task check(input string name, input logic [31:0] exp, input logic [31:0] act);
        compares = compares + 1;
        if (act !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s expected %h seen %h", name, exp, act);
        end
    endtask
    task wrap_up;
        $display("mismatches %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task fail_wait(input string name);
        error_cnt = error_cnt + 1;
        $display("mismatch %s expected answer seen none", name);
        wrap_up;
    endtask
    // One bus access; the request stands until waitrequest is low at an edge
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        integer t;
        logic wt;
        @(posedge REF_CLK);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        wt = 1'b1;
        for (t = 0; wt !== 1'b0; t = t + 1) begin
            if (t > 50) fail_wait("waitrequest");
            @(negedge REF_CLK);
            wt = wait_req;
            got = rdata;
            @(posedge REF_CLK);
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Wait for n group fetches, optionally prove the pass has stopped, check addresses
    task expect_pass(input integer cnt, input integer stop);
        integer t;
        for (t = 0; fetch_q.size() < cnt; t = t + 1) begin
            if (t > 20000) fail_wait("fetch");
            @(negedge REF_CLK);
        end
        if (stop) repeat (40) @(negedge REF_CLK);
        if (stop) check("fetch count", cnt, fetch_q.size());
        for (t = 0; t < cnt; t = t + 1) check("fetch addr", s + t % GRPS, fetch_q[t]);
        fetch_q.delete();
    endtask
    // Main sequence
    initial begin
        seed = xs(32'd72832);
        s = seed % 1000 + 1;
        repeat (6) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        check("idle sample", {2'h0, `IDLE_SAMPLE}, {mrk, smp});
        bus(1'b0, `OFS_CTRL, 32'h0);
        check("ctrl reset", `CTRL_RESET, got);
        bus(1'b0, `OFS_TRIG_IVL, 32'h0);
        check("interval reset", `IVL_RESET, got);
        bus(1'b0, 6'h3C, 32'h0);
        check("unmapped", 32'h0, got);
        for (i = 0; i < 2; i = i + 1) begin
            bus(1'b1, `OFS_TRIG_IVL, i ? 32'd5000 : 32'd5);
            bus(1'b0, `OFS_TRIG_IVL, 32'h0);
            check("interval value", i ? 32'd5000 : 32'd5, got);
            bus(1'b1, `OFS_SEG_LEN, i ? 32'd961 : 32'd956);
            bus(1'b0, `OFS_STATUS, 32'h0);
            check("length error", 32'h1, got[`STAT_LEN_ERR]);
            bus(1'b1, `OFS_STATUS, 32'h2);
        end
        ref_pin <= 1'b1;
        bus(1'b1, `OFS_CTRL, 32'h20);
        @(negedge REF_CLK);
        check("ref select", 32'h1, ref_ext);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check("ref pin", 32'h1, got[10]);
        bus(1'b1, `OFS_SEG_SEL, 32'h0);
        bus(1'b1, `OFS_SEG_START, s * 4);
        bus(1'b1, `OFS_SEG_LEN, `LEN_MIN_PTS);
        bus(1'b1, `OFS_SEG_REP, 32'h1);
        bus(1'b1, `OFS_SEQ_COUNT, 32'h1);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check("length ok", 32'h0, got[`STAT_LEN_ERR]);
        // Continuous: first groups reach the outputs point0 first, then the pass wraps
        bus(1'b1, `OFS_CTRL, 32'h1);
        for (n = 0; mem_rd !== 1'b1; n = n + 1) begin
            if (n > 100) fail_wait("start");
            @(negedge REF_CLK);
        end
        repeat (4) @(negedge REF_CLK);
        for (j = 0; j < 8; j = j + 1) begin
            n = s + j / 4;
            check("point", {n[1:0] ^ j[1:0], n[5:0], j[1:0]}, {mrk, smp});
            @(negedge REF_CLK);
        end
        expect_pass(2 * GRPS + 8, 0);
        bus(1'b1, `OFS_CTRL, 32'h0);
        repeat (40) @(negedge REF_CLK);
        fetch_q.delete();
        // Triggered by pin rising, pin falling, button, command; then enhanced by command
        for (i = 0; i < 5; i = i + 1) begin
            bus(1'b1, `OFS_SEG_REP, i == 3 ? 32'h2 : 32'h1);
            bus(1'b1, `OFS_CTRL, (i == 4 ? 32'h7 : 32'h3) | (i == 1 ? 32'h8 : 32'h0));
            expect_pass(0, 1);
            if (i < 3) begin
                @(posedge REF_CLK);
                trig_pin <= (i == 0);
                trig_btn <= (i == 2);
            end else bus(1'b1, `OFS_CMD, 32'h1 << `CMD_TRIG);
            expect_pass(i == 3 ? 2 * GRPS : GRPS, 1);
            @(posedge REF_CLK);
            trig_btn <= 1'b0;
        end
        // Two entries: one trigger plays both once; in enhanced an event replays entry 0
        bus(1'b1, `OFS_SEG_JUMP, 32'h0);
        bus(1'b1, `OFS_SEG_SEL, 32'h1);
        bus(1'b1, `OFS_SEG_START, s * 4);
        bus(1'b1, `OFS_SEG_LEN, `LEN_MIN_PTS);
        bus(1'b1, `OFS_SEG_REP, 32'h1);
        bus(1'b1, `OFS_SEQ_COUNT, 32'h2);
        for (i = 0; i < 2; i = i + 1) begin
            bus(1'b1, `OFS_CTRL, i ? 32'h7 : 32'h3);
            ev_pin <= i[0];
            bus(1'b1, `OFS_CMD, 32'h1 << `CMD_TRIG);
            expect_pass(i ? 3 * GRPS : 2 * GRPS, 1);
        end
        // Gated by the pin, then by the remote gate bit
        bus(1'b1, `OFS_CTRL, 32'h5);
        expect_pass(0, 1);
        @(posedge REF_CLK);
        trig_pin <= 1'b1;
        expect_pass(20, 0);
        @(posedge REF_CLK);
        trig_pin <= 1'b0;
        repeat (20) @(negedge REF_CLK);
        fetch_q.delete();
        expect_pass(0, 1);
        bus(1'b1, `OFS_CTRL, 32'h45);
        expect_pass(20, 0);
        // Internal timer: an interval outside the range acts as the nearest limit
        for (i = 0; i < 2; i = i + 1) begin
            bus(1'b1, `OFS_CTRL, 32'h0);
            bus(1'b1, `OFS_TRIG_IVL, i ? 32'd5000 : 32'd5);
            bus(1'b1, `OFS_CTRL, 32'h13);
            j = i ? 1000 : `TRIG_MIN_CYC;
            for (n = 0; mem_rd !== 1'b1; n = n + 1) begin
                if (n > 3000) fail_wait("timer");
                @(negedge REF_CLK);
            end
            check("timer start", 1, n > j + 5 && n < j + 10);
        end
        wrap_up;
    end
endmodule // testbench
